// ===== hdl/sce_execute.sv
`include "sce_regs.svh"
`default_nettype none
module sce_execute (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`SCE_WORD_W-1:0] mem_rdata,
   input wire logic [`SCE_IRQ_W-1:0] irq_pins,
   output var sce_pkg::sce_mem_req_t mem_req,
   output logic [`SCE_CELL_W-1:0] top_value,
   output logic [`SCE_CELL_W-1:0] addr_value,
   output logic int_enabled
);
   import sce_pkg::*;

   // Short slot opcode of the current instruction word
   function automatic logic [4:0] slot_op(input logic [15:0] w, input logic [1:0] s);
      logic [4:0] r;
      r = w[4:0];
      if (s == 2'h1) begin
         r = w[14:10];
      end else if (s == 2'h2) begin
         r = w[9:5];
      end
      return r;
   endfunction : slot_op

   // Word increment with wrap
   function automatic logic [15:0] inc16(input logic [15:0] v);
      return 16'(v + 16'h0001);
   endfunction : inc16

   sce_state_t state_reg, state_next;
   logic [1:0] slot_reg, slot_next;
   logic [15:0] ir_reg, ir_next;
   logic [15:0] pc_reg, pc_next;
   logic [16:0] t_reg, t_next;
   logic [16:0] a_reg, a_next;
   logic [3:0] sp_reg, sp_next;
   logic [3:0] rp_reg, rp_next;
   logic int_en_reg, int_en_next;
   sce_mem_req_t mem_req_reg, mem_req_next;
   logic [4:0] irq_meta_reg, irq_sync_reg;
   logic [16:0] ps_mem [`SCE_STK_DEPTH];
   logic [16:0] rs_mem [`SCE_STK_DEPTH];
   logic ps_we, rs_we, advance;
   logic [3:0] rs_waddr;
   logic [16:0] rs_wdata;
   logic [16:0] s_top, r_top, mul_sum;
   logic [4:0] cur_op;

   assign s_top = ps_mem[sp_reg];
   assign r_top = rs_mem[rp_reg];
   // RULE20: five-bit slot field
   assign cur_op = slot_op(ir_reg, slot_reg);
   // RULE12: conditional add of second item
   assign mul_sum = {1'b0, t_reg[15:0]} + (a_reg[0] ? {1'b0, s_top[15:0]} : 17'h0_0000);

   // Interrupt line synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_meta_reg <= 5'h00;
         irq_sync_reg <= 5'h00;
      end else begin
         irq_meta_reg <= irq_pins;
         irq_sync_reg <= irq_meta_reg;
      end
   end

   // Sequencer and datapath next values
   always_comb begin
      state_next = state_reg;
      slot_next = slot_reg;
      ir_next = ir_reg;
      pc_next = pc_reg;
      t_next = t_reg;
      a_next = a_reg;
      sp_next = sp_reg;
      rp_next = rp_reg;
      int_en_next = int_en_reg;
      mem_req_next = '{rd: 1'b0, addr: mem_req_reg.addr};
      ps_we = 1'b0;
      rs_we = 1'b0;
      rs_waddr = 4'(rp_reg + 4'h1);
      rs_wdata = {1'b0, pc_reg};
      advance = 1'b0;
      case (state_reg)
         ST_FETCH: begin
            mem_req_next = '{rd: 1'b1, addr: pc_reg};
            state_next = ST_WAIT;
         end
         ST_WAIT: begin
            state_next = ST_FIRST;
         end
         ST_FIRST: begin
            // RULE5: forced call to sampled vector
            if (int_en_reg && (irq_sync_reg != 5'h00)) begin
               rs_we = 1'b1;
               rp_next = rs_waddr;
               pc_next = {11'h000, irq_sync_reg};
               // RULE6: block further interrupts
               int_en_next = 1'b0;
               state_next = ST_FETCH;
            end else if (!mem_rdata[15]) begin
               // Subroutine call in the first slot
               rs_we = 1'b1;
               rs_wdata = {1'b0, inc16(pc_reg)};
               rp_next = rs_waddr;
               pc_next = {pc_reg[15], mem_rdata[14:0]};
               state_next = ST_FETCH;
            end else begin
               ir_next = mem_rdata;
               pc_next = inc16(pc_reg);
               slot_next = 2'h1;
               state_next = ST_SLOT;
            end
         end
         ST_SLOT: begin
            advance = 1'b1;
            case (cur_op)
               `SCE_OP_DROP: begin
                  // RULE1: pop second item into top
                  t_next = s_top;
                  sp_next = 4'(sp_reg - 4'h1);
               end
               `SCE_OP_DUP: begin
                  // RULE2: push copy of top
                  ps_we = 1'b1;
                  sp_next = 4'(sp_reg + 4'h1);
               end
               `SCE_OP_IE: begin
                  // RULE3: enable interrupts
                  int_en_next = 1'b1;
               end
               `SCE_OP_LIT: begin
                  // RULE8: read following program word
                  mem_req_next = '{rd: 1'b1, addr: pc_reg};
                  state_next = ST_LDWAIT;
                  advance = 1'b0;
               end
               `SCE_OP_LDA, `SCE_OP_LDAI: begin
                  // RULE9: read at address register
                  mem_req_next = '{rd: 1'b1, addr: a_reg[15:0]};
                  state_next = ST_LDWAIT;
                  advance = 1'b0;
               end
               `SCE_OP_COPYA: begin
                  // RULE10: address register with carry into top
                  ps_we = 1'b1;
                  sp_next = 4'(sp_reg + 4'h1);
                  t_next = a_reg;
               end
               `SCE_OP_MUL: begin
                  // RULE13: shift pair right after add
                  t_next = {1'b0, mul_sum[16:1]};
                  a_next = {a_reg[16], mul_sum[0], a_reg[15:1]};
               end
               `SCE_OP_LOOP: begin
                  // RULE14: counted loop back within page
                  if (slot_reg == 2'h1) begin
                     advance = 1'b0;
                     state_next = ST_FETCH;
                     if (r_top != 17'h0_0000) begin
                        rs_we = 1'b1;
                        rs_waddr = rp_reg;
                        rs_wdata = 17'(r_top - 17'h0_0001);
                        pc_next = {pc_reg[15:10], ir_reg[9:0]};
                     end else begin
                        rp_next = 4'(rp_reg - 4'h1);
                     end
                  end
               end
               `SCE_OP_NOP: begin
                  // RULE16: flush remaining slots
                  advance = 1'b0;
                  state_next = ST_FETCH;
               end
               `SCE_OP_OVER: begin
                  // RULE17: second item with carry into top
                  ps_we = 1'b1;
                  sp_next = 4'(sp_reg + 4'h1);
                  t_next = s_top;
               end
               `SCE_OP_POPR: begin
                  // RULE18: return top into top
                  ps_we = 1'b1;
                  sp_next = 4'(sp_reg + 4'h1);
                  t_next = r_top;
                  rp_next = 4'(rp_reg - 4'h1);
               end
               default: begin
               end
            endcase
         end
         ST_LDWAIT: begin
            state_next = ST_LDDATA;
         end
         ST_LDDATA: begin
            // RULE19: loaded value with carry bit cleared
            ps_we = 1'b1;
            sp_next = 4'(sp_reg + 4'h1);
            t_next = {1'b0, mem_rdata};
            advance = 1'b1;
            if (cur_op == `SCE_OP_LIT) begin
               pc_next = inc16(pc_reg);
            end
            // RULE11: post-increment address register
            if (cur_op == `SCE_OP_LDAI) begin
               a_next = {a_reg[16], inc16(a_reg[15:0])};
            end
         end
         default: begin
            state_next = ST_FETCH;
         end
      endcase
      if (advance) begin
         if (slot_reg == 2'h3) begin
            state_next = ST_FETCH;
         end else begin
            slot_next = 2'(slot_reg + 2'h1);
            state_next = ST_SLOT;
         end
      end
   end

   // Sequencer and datapath registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_FETCH;
         slot_reg <= 2'h1;
         ir_reg <= 16'h0000;
         pc_reg <= `SCE_PC_RESET;
         t_reg <= 17'h0_0000;
         a_reg <= 17'h0_0000;
         sp_reg <= 4'h0;
         rp_reg <= 4'h0;
         // RULE4: interrupts off after power-up
         int_en_reg <= 1'b0;
         mem_req_reg <= '{rd: 1'b0, addr: 16'h0000};
      end else begin
         state_reg <= state_next;
         slot_reg <= slot_next;
         ir_reg <= ir_next;
         pc_reg <= pc_next;
         t_reg <= t_next;
         a_reg <= a_next;
         sp_reg <= sp_next;
         rp_reg <= rp_next;
         int_en_reg <= int_en_next;
         mem_req_reg <= mem_req_next;
      end
   end

   // Stack storage, no reset needed
   always_ff @(posedge clk) begin
      if (ps_we) begin
         ps_mem[4'(sp_reg + 4'h1)] <= t_reg;
      end
      if (rs_we) begin
         rs_mem[rs_waddr] <= rs_wdata;
      end
   end

   // Outputs straight from registers
   assign mem_req = mem_req_reg;
   assign top_value = t_reg;
   assign addr_value = a_reg;
   assign int_enabled = int_en_reg;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence seq_op(logic [4:0] op);
      (state_reg == ST_SLOT) && (cur_op == op);
   endsequence
   sequence seq_load(logic [4:0] op);
      seq_op(op) ##1 (state_reg == ST_LDWAIT) ##1 (state_reg == ST_LDDATA);
   endsequence

   // RULE1: drop check
   a_discard_top: assert property (seq_op(`SCE_OP_DROP) |=> // RULE1
      (t_reg == $past(s_top)) && (sp_reg == 4'($past(sp_reg) - 4'h1)))
      else $error("discard did not pop second item");
   // RULE2: dup check
   a_dup_top: assert property (seq_op(`SCE_OP_DUP) |=> // RULE2
      (t_reg == $past(t_reg)) && (s_top == $past(t_reg)))
      else $error("duplicate did not copy top");
   // RULE3: enable check
   a_int_enable: assert property (seq_op(`SCE_OP_IE) |=> int_en_reg) // RULE3
      else $error("interrupt enable not set");
   // RULE6: enable only through opcode
   a_int_stays_off: assert property ( // RULE6
      (!int_en_reg && !((state_reg == ST_SLOT) && (cur_op == `SCE_OP_IE))) |=> !int_en_reg)
      else $error("interrupts enabled without enable opcode");
   // RULE5: vector call
   a_int_vector: assert property ( // RULE5
      ((state_reg == ST_FIRST) && int_en_reg && (irq_sync_reg != 5'h00)) |=>
      (pc_reg == {11'h000, $past(irq_sync_reg)}) && !int_en_reg &&
      (r_top == {1'b0, $past(pc_reg)}) ##1 mem_req.rd && (mem_req.addr == $past(pc_reg)))
      else $error("interrupt call wrong");
   // RULE8: literal load
   a_lit_load: assert property (seq_load(`SCE_OP_LIT) |=> // RULE8
      (t_reg == {1'b0, $past(mem_rdata)}) && (pc_reg == inc16($past(pc_reg))))
      else $error("literal load wrong");
   // RULE9: load request address
   a_load_addr: assert property (seq_op(`SCE_OP_LDA) |=> // RULE9
      mem_req.rd && (mem_req.addr == $past(a_reg[15:0])) ##2 (a_reg == $past(a_reg, 3)))
      else $error("load via address register wrong");
   // RULE11: post increment
   a_load_inc: assert property (seq_load(`SCE_OP_LDAI) |=> // RULE11
      (a_reg[15:0] == inc16($past(a_reg[15:0]))) && !t_reg[`SCE_CARRY_BIT])
      else $error("auto increment load wrong");
   // RULE12: multiply without add
   a_mul_noadd: assert property ((seq_op(`SCE_OP_MUL) and (!a_reg[0])) |=> // RULE12
      (t_reg == {2'h0, $past(t_reg[15:1])}) && (a_reg[15] == $past(t_reg[0])))
      else $error("multiply step shift wrong");
   // RULE14: loop branch taken
   a_loop_taken: assert property ( // RULE14
      (seq_op(`SCE_OP_LOOP) and (slot_reg == 2'h1) and (r_top != 17'h0_0000)) |=>
      (pc_reg == {$past(pc_reg[15:10]), $past(ir_reg[9:0])}) &&
      (r_top == 17'($past(r_top) - 17'h0_0001)))
      else $error("loop branch wrong");
   // RULE16: nop flush
   a_nop_flush: assert property (seq_op(`SCE_OP_NOP) |=> (state_reg == ST_FETCH)) // RULE16
      else $error("no operation did not flush word");
   // RULE18: return stack to top
   a_ret_to_top: assert property (seq_op(`SCE_OP_POPR) |=> // RULE18
      (t_reg == $past(r_top)) && (s_top == $past(t_reg)))
      else $error("return to top wrong");
   // RULE10: address register into top
   a_copy_a_top: assert property (seq_op(`SCE_OP_COPYA) |=> // RULE10
      (t_reg == $past(a_reg)) && (s_top == $past(t_reg)))
      else $error("copy of address register wrong");
   // RULE17: second item into top
   a_copy_second: assert property (seq_op(`SCE_OP_OVER) |=> // RULE17
      (t_reg == $past(s_top)) && (s_top == $past(t_reg)))
      else $error("copy of second item wrong");
   // RULE12: multiply with add
   a_mul_add: assert property ((seq_op(`SCE_OP_MUL) and a_reg[0]) |=> // RULE12
      (t_reg == 17'(({1'b0, $past(t_reg[15:0])} + {1'b0, $past(s_top[15:0])}) >> 1)))
      else $error("multiply step add wrong");
endmodule : sce_execute
`default_nettype wire

// ===== hdl/sce_regs.svh
// Overview of operation
// RULE1: Opcode 31 pops the second item into top, old top lost, carry restored.
// RULE2: Opcode 26 pushes a copy of top; top and carry unchanged.
// RULE3: Opcode 6 enables response to interrupt lines; stacks and carry unchanged.
// RULE4: After power-up external interrupts stay disabled until opcode 6 runs.
// RULE5: When enabled, lines sampled in first slot; any high forces call to pattern.
// RULE6: Taking an interrupt disables further interrupts until opcode 6 runs again.
// RULE7: Software fills vector words 1 to 31 before enabling interrupts.
// RULE8: Opcode 10 pushes next program word, skips it, clears carry.
// RULE9: Opcode 11 pushes memory at address register, register kept, carry cleared.
// RULE10: Opcode 25 pushes top, copies address register and its carry into top.
// RULE11: Opcode 9 pushes memory at address register, clears carry, increments register.
// RULE12: Opcode 19 adds second item if address bit 0 set, shifts pair right.
// RULE13: Sixteen multiply steps leave product plus initial top in the pair.
// RULE14: Opcode 5 decrements nonzero return top and branches in page, else pops.
// RULE15: Programs place opcode 5 only in the second slot.
// RULE16: Opcode 30 returns to first slot and fetches the next word.
// RULE17: Opcode 27 pushes top and copies second item with its carry into top.
// RULE18: Opcode 24 pops return top into top, pushing old top.
// RULE19: Carry is held as bit 16 of the top register.
// RULE20: Each short slot is a 5-bit opcode, codes 0 to 31.
`ifndef SCE_REGS_SVH
`define SCE_REGS_SVH
`define SCE_WORD_W 16
`define SCE_CELL_W 17
`define SCE_CARRY_BIT 16
`define SCE_PTR_W 4
`define SCE_STK_DEPTH 16
`define SCE_IRQ_W 5
`define SCE_PAGE_BITS 10
`define SCE_PC_RESET 16'h0000
`define SCE_OP_LOOP 5'h05
`define SCE_OP_IE 5'h06
`define SCE_OP_LDAI 5'h09
`define SCE_OP_LIT 5'h0a
`define SCE_OP_LDA 5'h0b
`define SCE_OP_MUL 5'h13
`define SCE_OP_POPR 5'h18
`define SCE_OP_COPYA 5'h19
`define SCE_OP_DUP 5'h1a
`define SCE_OP_OVER 5'h1b
`define SCE_OP_NOP 5'h1e
`define SCE_OP_DROP 5'h1f
`endif

// ===== hdl/sce_pkg.sv
`default_nettype none
package sce_pkg;
   // Memory read request
   typedef struct packed {
      logic rd;
      logic [15:0] addr;
   } sce_mem_req_t;
   // Sequencer states
   typedef enum logic [5:0] {
      ST_FETCH = 6'b00_0001,
      ST_WAIT = 6'b00_0010,
      ST_FIRST = 6'b00_0100,
      ST_SLOT = 6'b00_1000,
      ST_LDWAIT = 6'b01_0000,
      ST_LDDATA = 6'b10_0000
   } sce_state_t;
endpackage : sce_pkg
`default_nettype wire

// ===== bench/sce_mem_model.sv
`include "sce_regs.svh"
`default_nettype none
module sce_mem_model (
   input wire logic clk,
   input wire sce_pkg::sce_mem_req_t mem_req,
   output var logic [`SCE_WORD_W-1:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   import sce_pkg::*;
   // Program, data and vector words, loaded by the bench
   logic [`SCE_WORD_W-1:0] mem [0:63];
   // Word answers one cycle after the strobe, then scrambles so stale data never holds
   initial mem_rdata = 16'h0000;
   always @(posedge clk) begin
      if (mem_req.rd) begin
         mem_rdata <= mem[mem_req.addr[5:0]];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : sce_mem_model
`default_nettype wire

// ===== bench/stack_cpu_op_execute_bench.sv
`include "sce_regs.svh"
`default_nettype none
module stack_cpu_op_execute_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import sce_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [`SCE_IRQ_W-1:0] irq_pins = 5'h00;
   logic [`SCE_WORD_W-1:0] mem_rdata;
   sce_mem_req_t mem_req;
   logic [`SCE_CELL_W-1:0] top_value;
   logic [`SCE_CELL_W-1:0] addr_value;
   logic int_enabled;
   int fail_count = 0;
   int num_checks = 0;
   // 10 MHz clock
   always #50 clk = ~clk;
   // Core and its memory
   sce_execute dut (
      .clk(clk), .rst_n(rst_n), .mem_rdata(mem_rdata), .irq_pins(irq_pins),
      .mem_req(mem_req), .top_value(top_value), .addr_value(addr_value),
      .int_enabled(int_enabled)
   );
   sce_mem_model mem_model (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
   // Compare one value
   task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Three-slot instruction word
   function automatic logic [15:0] w3(input logic [4:0] a, input logic [4:0] b,
                                      input logic [4:0] c);
      return {1'b1, a, b, c};
   endfunction : w3
   // Every word calls itself, so any address is a parking loop
   task automatic clear_mem;
      for (int i = 0; i < 64; i++) begin
         mem_model.mem[i] = i[15:0];
      end
   endtask : clear_mem
   task automatic do_reset;
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      check("rd in reset", {16'h0000, mem_req.rd}, 17'h0_0000);
      check("top in reset", top_value, 17'h0_0000);
      check("addr in reset", addr_value, 17'h0_0000);
      check("ie in reset", {16'h0000, int_enabled}, 17'h0_0000);
      rst_n = 1'b1;
   endtask : do_reset
   task automatic wait_fetch(input logic [15:0] a);
      int n;
      n = 0;
      while (!(mem_req.rd === 1'b1 && mem_req.addr === a) && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 2000) begin
         fail_count++;
         $display("[FAIL] fetch address expected %h seen none", a);
         report_and_stop();
      end
   endtask : wait_fetch
   // Second fetch of a parking word proves the program got there
   task automatic wait_halt(input logic [15:0] a);
      wait_fetch(a);
      @(posedge clk);
      #1;
      wait_fetch(a);
   endtask : wait_halt
   task automatic test_stack_ops;
      clear_mem();
      irq_pins = 5'h13;
      mem_model.mem[0] = w3(`SCE_OP_LIT, `SCE_OP_LIT, `SCE_OP_LIT);
      mem_model.mem[1] = 16'h1234;
      mem_model.mem[2] = 16'habcd;
      mem_model.mem[3] = 16'h5a5a;
      mem_model.mem[4] = w3(`SCE_OP_OVER, `SCE_OP_DROP, `SCE_OP_DUP);
      mem_model.mem[5] = w3(`SCE_OP_DROP, `SCE_OP_NOP, `SCE_OP_DROP);
      do_reset();
      wait_halt(16'h0006);
      check("stack top", top_value, {1'b0, 16'h5a5a});
      check("ie masked", {16'h0000, int_enabled}, 17'h0_0000);
      irq_pins = 5'h00;
      $display("test_stack_ops done");
   endtask : test_stack_ops
   task automatic test_addr_loads;
      clear_mem();
      mem_model.mem[0] = 16'h0010;
      mem_model.mem[2] = 16'h4321;
      mem_model.mem['h10] = w3(`SCE_OP_LDAI, `SCE_OP_LDAI, `SCE_OP_COPYA);
      mem_model.mem['h11] = w3(`SCE_OP_LDA, `SCE_OP_NOP, `SCE_OP_NOP);
      do_reset();
      wait_fetch(16'h0011);
      check("copied addr", top_value, {1'b0, 16'h0002});
      wait_halt(16'h0012);
      check("load top", top_value, {1'b0, 16'h4321});
      check("addr reg", addr_value, {1'b0, 16'h0002});
      $display("test_addr_loads done");
   endtask : test_addr_loads
   task automatic test_multiply;
      clear_mem();
      mem_model.mem[0] = w3(`SCE_OP_LDAI, `SCE_OP_LDAI, `SCE_OP_LDAI);
      mem_model.mem[1] = w3(`SCE_OP_LDAI, `SCE_OP_LDAI, `SCE_OP_LIT);
      mem_model.mem[2] = 16'hf00d;
      mem_model.mem[3] = w3(`SCE_OP_LIT, `SCE_OP_MUL, `SCE_OP_MUL);
      mem_model.mem[4] = 16'h0011;
      for (int i = 5; i < 9; i++) begin
         mem_model.mem[i] = w3(`SCE_OP_MUL, `SCE_OP_MUL, `SCE_OP_MUL);
      end
      mem_model.mem[9] = w3(`SCE_OP_MUL, `SCE_OP_MUL, `SCE_OP_NOP);
      do_reset();
      wait_halt(16'h000a);
      // Product 5 x f00d plus initial top 0011
      check("product high", top_value, {1'b0, 16'h0004});
      check("product low", addr_value, {1'b0, 16'hb052});
      $display("test_multiply done");
   endtask : test_multiply
   task automatic test_interrupts;
      clear_mem();
      mem_model.mem[0] = w3(`SCE_OP_IE, `SCE_OP_NOP, `SCE_OP_NOP);
      mem_model.mem[11] = w3(`SCE_OP_POPR, `SCE_OP_IE, `SCE_OP_NOP);
      do_reset();
      wait_halt(16'h0001);
      check("ie set", {16'h0000, int_enabled}, {16'h0000, 1'b1});
      irq_pins = 5'h0b;
      wait_fetch(16'h000b);
      check("ie after take", {16'h0000, int_enabled}, 17'h0_0000);
      irq_pins = 5'h00;
      wait_halt(16'h000c);
      check("return addr", top_value, {1'b0, 16'h0001});
      check("ie again", {16'h0000, int_enabled}, {16'h0000, 1'b1});
      irq_pins = 5'h01;
      wait_fetch(16'h0001);
      repeat (30) @(posedge clk);
      #1;
      check("ie held off", {16'h0000, int_enabled}, 17'h0_0000);
      irq_pins = 5'h00;
      $display("test_interrupts done");
   endtask : test_interrupts
   task automatic test_loop_back;
      clear_mem();
      mem_model.mem[5] = 16'h0010;
      mem_model.mem['h10] = w3(`SCE_OP_LDAI, `SCE_OP_NOP, `SCE_OP_NOP);
      mem_model.mem['h11] = {1'b1, `SCE_OP_LOOP, 10'h010};
      mem_model.mem[0] = 16'h0005;
      do_reset();
      wait_halt(16'h0012);
      check("loop count", addr_value, {1'b0, 16'h0007});
      $display("test_loop_back done");
   endtask : test_loop_back
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      test_stack_ops();
      test_addr_loads();
      test_multiply();
      test_interrupts();
      test_loop_back();
      report_and_stop();
   end
endmodule : stack_cpu_op_execute_bench
`default_nettype wire
